// file: hw/iopd_pin_drive.sv
`timescale 1ns/1ps
// Combinational drive decoder for one pin
module iopd_pin_drive
	import iopd_pkg::*;
(
	input wire logic [2:0] mode,        // Drive mode of this pin
	input wire logic data,              // Value to drive
	input wire logic aux_oe,            // Auxiliary output enable
	input wire logic push_pull_only,    // Serial bus pin
	output iopd_drv_type drv            // Resulting driver state
);
	logic [2:0] eff_mode;
	logic [2:0] pp_mode;
	// Serial bus pins: any output mode collapses to push-pull
	assign pp_mode = (push_pull_only && mode > DM_HIZ_DIGITAL) ? DM_STRONG : mode; // [R15]
	assign eff_mode = aux_oe ? pp_mode : DM_HIZ_DIGITAL; // [R17]
	// Table decode of drive state
	assign drv.drive_hi = data && (eff_mode == DM_RES_DOWN || eff_mode == DM_OD_HIGH
		|| eff_mode == DM_STRONG); // [R4] [R6] [R7]
	assign drv.drive_lo = !data && (eff_mode == DM_RES_UP || eff_mode == DM_OD_LOW
		|| eff_mode == DM_STRONG); // [R4] [R5] [R7]
	assign drv.pull_up = data && (eff_mode == DM_RES_UP || eff_mode == DM_RES_BOTH); // [R4] [R7]
	assign drv.pull_dn = !data && (eff_mode == DM_RES_DOWN || eff_mode == DM_RES_BOTH); // [R4] [R7]
	// Input buffer off only in analog high-Z
	assign drv.in_en = (eff_mode != DM_HIZ_ANALOG); // [R2] [R3]
endmodule

// file: hw/iopd_port.sv
`timescale 1ns/1ps
// One eight-pin port: drive decode, pin-state read, edge interrupts
module iopd_port
	import iopd_pkg::*;
#(
	parameter int NPIN = PINS,
	parameter logic [NPIN-1:0] PUSH_PULL_PINS = '0  // Serial bus pins
)(
	input wire logic clk,                         // 250 MHz system clock
	input wire logic srst,                        // Sync reset, active high
	input wire logic port_wr,                     // Port-form write strobe
	input wire logic [2:0] port_sel,              // Port-form register select
	input wire logic [NPIN-1:0] port_wdata,       // One bit per pin
	input wire logic pin_wr,                      // Pin-form write strobe
	input wire logic [2:0] pin_idx,               // Pin addressed by pin form
	input wire logic [PINREG_W-1:0] pin_wdata,    // Pin-form write data
	input wire logic [NPIN-1:0] array_out,        // Digital array output signals
	input wire logic [NPIN-1:0] aux_oe,           // Auxiliary output enables
	input wire logic [NPIN-1:0] pad_in,           // Level seen at each pad
	input wire logic stat_rd,                     // Status read, clears status
	output iopd_drv_type [NPIN-1:0] pad_drv,      // Driver state per pin
	output logic [NPIN-1:0] pin_state_read,       // Pin-state register
	output logic [NPIN-1:0] port_output_value,    // Output data readback
	output logic [NPIN-1:0] array_in,             // Pin states to the array
	output logic [NPIN-1:0] int_status,           // Sticky interrupt status
	output logic port_irq                         // Port interrupt request
);
	iopd_pin_cfg_type [NPIN-1:0] cfg;
	iopd_drv_type [NPIN-1:0] next_drv;
	logic [NPIN-1:0] prev_state;
	logic [NPIN-1:0] ev;
	logic [NPIN-1:0] next_status;
	logic [NPIN-1:0] data_sel;
	logic [NPIN-1:0] in_live;

	genvar i;
	generate
		for (i = 0; i < NPIN; i++) begin : g_pin
			logic hit_port;
			logic hit_pin;
			iopd_pin_cfg_type next_cfg;
			// Port-form and pin-form writes reach the same bits
			assign hit_port = port_wr;
			assign hit_pin = pin_wr && (pin_idx == 3'(i));
			always_comb begin
				next_cfg = cfg[i];
				if (hit_port) begin // [R12]
					unique case (port_sel)
						PSEL_DATA: next_cfg.output_data_write = port_wdata[i];
						PSEL_BYP: next_cfg.bypass = port_wdata[i];
						PSEL_IBD: next_cfg.in_buf_dis = port_wdata[i];
						PSEL_DM0: next_cfg.drive_mode_select[0] = port_wdata[i];
						PSEL_DM1: next_cfg.drive_mode_select[1] = port_wdata[i];
						PSEL_DM2: next_cfg.drive_mode_select[2] = port_wdata[i];
						PSEL_RISE: next_cfg.edge_sel[EDGE_RISE_BIT] = port_wdata[i];
						PSEL_FALL: next_cfg.edge_sel[EDGE_FALL_BIT] = port_wdata[i];
					endcase
				end
				// Pin form wins when both hit the same pin in one cycle
				if (hit_pin) begin // [R12]
					next_cfg.output_data_write = pin_wdata[PINREG_DATA];
					next_cfg.bypass = pin_wdata[PINREG_BYP];
					next_cfg.in_buf_dis = pin_wdata[PINREG_IBD];
					next_cfg.drive_mode_select = pin_wdata[PINREG_DM_LSB +: MODE_W]; // [R1]
					next_cfg.edge_sel = pin_wdata[PINREG_EDGE_LSB +: 2]; // [R10]
				end
			end
			// Configuration storage, analog high-Z after reset
			always_ff @(posedge clk) begin
				if (srst) begin
					cfg[i] <= '{edge_sel: EDGE_NONE, drive_mode_select: DM_RESET, // [R2]
						in_buf_dis: 1'b0, bypass: 1'b0, output_data_write: 1'b0};
				end else begin
					cfg[i] <= next_cfg;
				end
			end
			// Driven value: data register or array signal
			assign data_sel[i] = cfg[i].bypass ? array_out[i] : cfg[i].output_data_write; // [R8]
			iopd_pin_drive u_drive (
				.mode(cfg[i].drive_mode_select),
				.data(data_sel[i]),
				.aux_oe(aux_oe[i]),
				.push_pull_only(PUSH_PULL_PINS[i]),
				.drv(next_drv[i])
			);
			// Disabled buffer reads zero; also the explicit disable bit
			assign in_live[i] = next_drv[i].in_en && !cfg[i].in_buf_dis && pad_in[i]; // [R18]
			// Edge detect on the gated state, so a dead buffer raises at most one falling edge, in the cycle it goes dead
			assign ev[i] = (cfg[i].edge_sel[EDGE_RISE_BIT] && in_live[i] && !prev_state[i])
				|| (cfg[i].edge_sel[EDGE_FALL_BIT] && !in_live[i] && prev_state[i]); // [R10] [R18]
		end
	endgenerate

	// Set beats the read-clear in the same cycle; edges only, no level sense
	assign next_status = (stat_rd ? '0 : int_status) | ev; // [R16] [R14]

	// Pad driver and read paths, all registered
	always_ff @(posedge clk) begin
		if (srst) begin
			pad_drv <= '0;
			prev_state <= '0;
			pin_state_read <= '0;
			array_in <= '0;
			port_output_value <= '0;
		end else begin
			pad_drv <= next_drv; // [R13]
			prev_state <= in_live;
			pin_state_read <= in_live; // [R9]
			array_in <= in_live; // [R13]
			for (int k = 0; k < NPIN; k++) begin
				port_output_value[k] <= cfg[k].output_data_write; // [R9]
			end
		end
	end

	// Sticky status and one request line for the port
	always_ff @(posedge clk) begin
		if (srst) begin
			int_status <= '0;
			port_irq <= 1'b0;
		end else begin
			int_status <= next_status; // [R16]
			port_irq <= |next_status; // [R11]
		end
	end
endmodule

// file: inc/iopd_pkg.sv
// Notes on behaviour
// (R1) Each pin holds its own three-bit drive mode, one of eight.
// (R2) Mode 0: driver off, input buffer off; default after reset.
// (R3) Mode 1: output high impedance, input buffer on.
// (R4) Mode 2: resistive high / strong low; mode 3: strong high / resistive low.
// (R5) Mode 4: strong low for zero, high impedance for one.
// (R6) Mode 5: strong high for one, high impedance for zero.
// (R7) Mode 6: strong both ways; mode 7: resistive both ways.
// (R8) Driven value comes from output data, or from the array signal when bypassed.
// (R9) Pin-state read is separate from output data; reads never disturb writes.
// (R10) Each pin interrupts on rising, falling or both edges, chosen per pin.
// (R11) One interrupt request line per port combines its pin events.
// (R12) Settings reachable as port-wide registers and as per-pin registers.
// (R13) Processor and DMA may use every pin as input, output or both.
// (R14) No native level interrupts; level sensing lives in interconnect logic.
// (R15) Serial bus pins offer only push-pull digital output.
// (R16) A configured pin event sets its status bit and raises the port request.
// (R17) Auxiliary enable low gives high-Z digital input; high applies selected mode.
// (R18) Disabled input buffer reads zero and raises no edge events; the code flags a falling edge on disabling it while high.
package iopd_pkg;
	localparam int PINS = 8;
	localparam int MODE_W = 3;
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_RES_UP = 3'h2;
	localparam logic [2:0] DM_RES_DOWN = 3'h3;
	localparam logic [2:0] DM_OD_LOW = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG = 3'h6;
	localparam logic [2:0] DM_RES_BOTH = 3'h7;
	localparam logic [2:0] DM_RESET = DM_HIZ_ANALOG;
	// Edge select field, bit 0 rising, bit 1 falling
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	// Per-pin register layout
	localparam int PINREG_DATA = 0;
	localparam int PINREG_BYP = 1;
	localparam int PINREG_IBD = 2;
	localparam int PINREG_DM_LSB = 3;
	localparam int PINREG_EDGE_LSB = 6;
	localparam int PINREG_W = 8;
	// Port-wide register selector for port-form writes
	localparam logic [2:0] PSEL_DATA = 3'h0;
	localparam logic [2:0] PSEL_BYP = 3'h1;
	localparam logic [2:0] PSEL_IBD = 3'h2;
	localparam logic [2:0] PSEL_DM0 = 3'h3;
	localparam logic [2:0] PSEL_DM1 = 3'h4;
	localparam logic [2:0] PSEL_DM2 = 3'h5;
	localparam logic [2:0] PSEL_RISE = 3'h6;
	localparam logic [2:0] PSEL_FALL = 3'h7;

	// Driver state of one pin, resolved by the testbench
	typedef struct packed {
		logic drive_hi;   // strong high
		logic drive_lo;   // strong low
		logic pull_up;    // resistive high
		logic pull_dn;    // resistive low
		logic in_en;      // digital input buffer on
	} iopd_drv_type;

	// Per-pin configuration
	typedef struct packed {
		logic [1:0] edge_sel;
		logic [2:0] drive_mode_select;
		logic in_buf_dis;
		logic bypass;
		logic output_data_write;
	} iopd_pin_cfg_type;
endpackage

// file: test/iopd_board.sv
`timescale 1ns/1ps
module iopd_board import iopd_pkg::*; (
	input wire logic clk, // Clock
	input iopd_drv_type [7:0] pad_drv, // Device drivers
	input wire logic [7:0] ext_en, // Board drives pin
	input wire logic [7:0] ext_val, // Board level
	output logic [7:0] pad_level = '0 // Pad levels
);
	// Strong wins, board beats pulls; a floating pad wanders, never holds
	always @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			pad_level[i] <= pad_drv[i].drive_hi ? 1'b1 : pad_drv[i].drive_lo ? 1'b0 :
				ext_en[i] ? ext_val[i] : pad_drv[i].pull_up ? 1'b1 :
				pad_drv[i].pull_dn ? 1'b0 : ~pad_level[i];
		end
	end
endmodule

// file: test/iopd_port_sva.sv
`timescale 1ns/1ps
module iopd_port_sva import iopd_pkg::*; (
	input wire logic clk, // Clock
	input wire logic srst, // Reset
	input wire logic stat_rd, // Status clear
	input wire logic [7:0] aux_oe, // Enables
	input iopd_drv_type [7:0] pad_drv, // Drivers
	input wire logic [7:0] pin_state_read, // Pin state
	input wire logic [7:0] array_in, // To array
	input wire logic [7:0] int_status, // Flags
	input wire logic port_irq // Request
);
	logic [7:0] any, bad;
	// Drive summary per pin
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			any[i] = |pad_drv[i][4:1];
			bad[i] = !$onehot0(pad_drv[i][4:1]);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_irq; port_irq == |int_status; endproperty
	a_irq: assert property (p_irq) else $error("request not OR of flags");
	property p_one; bad == 8'h00; endproperty
	a_one: assert property (p_one) else $error("two drivers on");
	property p_arr; array_in == pin_state_read; endproperty
	a_arr: assert property (p_arr) else $error("array copy differs");
	property p_ev; (int_status & ~$past(int_status) & ~(pin_state_read ^
		$past(pin_state_read))) == 8'h00; endproperty
	a_ev: assert property (p_ev) else $error("flag without edge");
	property p_clr; stat_rd |=> (int_status & ~(pin_state_read ^
		$past(pin_state_read))) == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_stk; !stat_rd |=> ($past(int_status) & ~int_status) == 8'h00; endproperty
	a_stk: assert property (p_stk) else $error("flag lost");
	property p_aux; (aux_oe == 8'h00) [*3] |-> any == 8'h00; endproperty
	a_aux: assert property (p_aux) else $error("driving with enable low");
	property p_rise; $rose(port_irq) |-> pin_state_read != $past(pin_state_read); endproperty
	a_rise: assert property (p_rise) else $error("request without event");
endmodule
bind iopd_port iopd_port_sva u_iopd_port_sva (.clk, .srst, .stat_rd, .aux_oe, .pad_drv,
	.pin_state_read, .array_in, .int_status, .port_irq);

// file: test/iopd_port_tb_top.sv
`timescale 1ns/1ps
module iopd_port_tb_top import iopd_pkg::*;;
	logic clk = 0, srst = 1, port_wr = 0, pin_wr = 0, stat_rd = 0, chk = 0, port_irq;
	logic [2:0] port_sel = '0, pin_idx = '0;
	logic [7:0] port_wdata = '0, pin_wdata = '0, array_out = '0, aux_oe = 8'hff, ext_val = '0;
	logic [7:0] pad_lv, pin_state_read, array_in, int_status, last = '0, pov;
	logic chko = 0, chkp = 0;
	logic [7:0] qo[$];
	logic qp[$];
	iopd_drv_type [7:0] pad_drv;
	logic [7:0] qd[$], qs[$];
	int err_count = 0, comparisons = 0;
	always #2 clk = ~clk;
	iopd_port u_iopd_port (.clk, .srst, .port_wr, .port_sel, .port_wdata, .pin_wr, .pin_idx,
		.pin_wdata, .array_out, .aux_oe, .pad_in(pad_lv), .stat_rd, .pad_drv, .pin_state_read,
		.port_output_value(pov), .array_in, .int_status, .port_irq);
	iopd_board u_iopd_board (.clk, .pad_drv, .ext_en(8'h08), .ext_val, .pad_level(pad_lv));
	// Shared comparison and verdict
	task automatic tally(string n, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_drv(logic [7:0] n);
		tally("pad_drv", {3'h0, n[4:0]}, {3'h0, pad_drv[n[7:5]]});
	endtask
	task automatic cmp_stat(logic [7:0] e);
		tally("int_status", e, int_status);
	endtask
	task automatic cmp_irq(logic e);
		tally("port_irq", {7'h0, e}, {7'h0, port_irq});
	endtask
	task automatic cmp_out(logic [7:0] e);
		tally("port_output_value", e, pov);
	endtask
	// Only pin 3 has a board driver; the other pads wander
	task automatic cmp_pin(logic e);
		tally("pin_state_read", {7'h0, e}, {7'h0, pin_state_read[3]});
		tally("array_in", {7'h0, e}, {7'h0, array_in[3]});
	endtask
	task automatic complete_run;
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Expected drivers for one mode and data bit
	function automatic iopd_drv_type ex(logic [2:0] m, logic d);
		ex.in_en = m != 3'h0;
		ex.drive_hi = d && m inside {3'h3, 3'h5, 3'h6};
		ex.drive_lo = !d && m inside {3'h2, 3'h4, 3'h6};
		ex.pull_up = d && m inside {3'h2, 3'h7};
		ex.pull_dn = !d && m inside {3'h3, 3'h7};
	endfunction
	// Writes idle one edge after release so strobes are never set twice at once
	task automatic pw(logic [2:0] i, logic [7:0] d);
		pin_wr <= 1;
		pin_idx <= i;
		pin_wdata <= d;
		@(posedge clk) pin_wr <= 0;
		@(posedge clk);
	endtask
	task automatic pf(logic [2:0] s, logic [7:0] d);
		port_wr <= 1;
		port_sel <= s;
		port_wdata <= d;
		@(posedge clk) port_wr <= 0;
		@(posedge clk);
	endtask
	task automatic xd(logic [2:0] i, iopd_drv_type e);
		repeat (3) @(posedge clk);
		qd.push_back({i, e});
		chk <= 1;
		@(posedge clk) chk <= 0;
	endtask
	task automatic xo(logic [7:0] e);
		repeat (3) @(posedge clk);
		qo.push_back(e);
		chko <= 1;
		@(posedge clk) chko <= 0;
	endtask
	task automatic xp(logic e);
		repeat (3) @(posedge clk);
		qp.push_back(e);
		chkp <= 1;
		@(posedge clk) chkp <= 0;
	endtask
	task automatic stat_clr;
		repeat (4) @(posedge clk);
		qs.push_back(8'h00);
		stat_rd <= 1;
		@(posedge clk) stat_rd <= 0;
	endtask
	// Monitor: each appearing result takes the oldest note
	always @(posedge clk) begin
		logic [7:0] e;
		e = last;
		if (chk) cmp_drv(qd.pop_front());
		if (chko) cmp_out(qo.pop_front());
		if (chkp) cmp_pin(qp.pop_front());
		if (int_status !== last) begin
			if (qs.size()) e = qs.pop_front();
			cmp_stat(e);
			cmp_irq(|e);
		end
		last = int_status;
	end
	initial begin
		logic [2:0] i;
		logic [7:0] r;
		void'($urandom(9));
		repeat (6) @(posedge clk);
		srst <= 0;
		xd(3'h0, '0);
		for (int k = 0; k < 16; k++) begin
			i = 3'($urandom);
			pw(i, {2'h0, k[3:1], 2'h0, k[0]});
			xd(i, ex(k[3:1], k[0]));
		end
		r = $urandom;
		array_out <= r;
		pw(i, 8'h32);
		xd(i, ex(3'h6, r[i]));
		r = $urandom;
		pf(PSEL_DM0, 8'hff);
		pf(PSEL_DM1, 8'h00);
		pf(PSEL_DM2, 8'hff);
		pf(PSEL_DATA, r);
		pf(PSEL_BYP, 8'h00);
		xo(r);
		for (int j = 0; j < 8; j++) xd(3'(j), ex(3'h5, r[j]));
		aux_oe <= 8'h00;
		xd(i, 5'h01);
		aux_oe <= 8'hff;
		pw(3'h3, 8'h08);
		repeat (4) @(posedge clk);
		pw(3'h3, 8'hc8);
		qs.push_back(8'h08);
		ext_val <= 8'h08;
		xp(1'b1);
		stat_clr;
		qs.push_back(8'h08);
		ext_val <= 8'h00;
		xp(1'b0);
		stat_clr;
		pw(3'h3, 8'hcc);
		ext_val <= 8'h08;
		xp(1'b0);
		ext_val <= 8'h00;
		repeat (8) @(posedge clk);
		complete_run;
	end
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#40us;
		err_count++;
		complete_run;
	end
endmodule
